// ===== hw/tio_pkg.sv
/*
 * constants, field layout and helpers for the timed pin port unit.
 * assumes a single 100 MHz reference clock and word-addressed bus.
 */
package tio_pkg;
   // ***********************************************
   // sizes
   // ***********************************************
   localparam int NPORT = 5;
   localparam int NCB   = 6;
   localparam int NPIN  = 32;
   localparam int CNT_W = 16;
   localparam int REF_MHZ = 100;

   // ***********************************************
   // register map (word addresses)
   // ***********************************************
   localparam logic [2:0] F_CTRL  = 3'h0;
   localparam logic [2:0] F_DATA  = 3'h1;
   localparam logic [2:0] F_COND  = 3'h2;
   localparam logic [2:0] F_TIME  = 3'h3;
   localparam logic [2:0] F_COUNT = 3'h4;
   localparam logic [2:0] F_STAMP = 3'h5;
   localparam logic [5:0] A_LINK  = 6'h28;
   localparam logic [5:0] A_ISTAT = 6'h29;
   localparam logic [5:0] A_IMASK = 6'h2a;
   localparam logic [5:0] A_CB0   = 6'h30;

   // ***********************************************
   // port control fields
   // ***********************************************
   localparam int C_EN    = 0;
   localparam int C_OUT   = 1;
   localparam int C_OC    = 2;
   localparam int C_TIMED = 3;
   localparam int C_STRB  = 4;
   localparam int C_CM    = 5;
   localparam int C_CB    = 8;
   localparam int CTRL_W  = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // ***********************************************
   // clock block fields
   // ***********************************************
   localparam int CB_SRC  = 0;
   localparam int CB_DIV  = 8;
   localparam logic [15:0] CB_RST = 16'h0000;

   localparam logic [NPIN-1:0] LINK_PINS = 32'hc000_0000;

   typedef enum logic [1:0] {
      COND_NONE = 2'b00,
      COND_EQ   = 2'b01,
      COND_NE   = 2'b10
   } cond_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } bus_t;

   // pins covered by port k; all ports start at pin 0
   function automatic logic [NPIN-1:0] port_mask(input int k);
      case (k)
         0: port_mask = 32'h0000_0001;
         1: port_mask = 32'h0000_000f;
         2: port_mask = 32'h0000_00ff;
         3: port_mask = 32'h0000_ffff;
         default: port_mask = 32'hffff_ffff;
      endcase
   endfunction
endpackage

// ===== hw/tio_port_unit.sv
/*
 * timed pin port unit: five ports of 1, 4, 8, 16 and 32 pins sharing
 * 32 pins, six clock blocks, counters, timestamps, strobes, events.
 * assumes synchronous pin inputs and an external pad that resolves
 * pin_out/pin_oe; link logic outside takes the link pins when enabled.
 */
// The Avalon-MM register port and the register addresses were decided locally.
// Functional notes
// - ports of width 1, 4, 8, 16 and 32 pins on fixed pins
// - all pins of one port share one direction
// - drive pins or sample them, optionally after a pin condition
// - core writes complete in one bus cycle; reads take two, with one wait cycle
// - open collector per port: zero pulls low, one releases pin
// - data moves through a shift register and a transfer register
// - a 16-bit port counter can gate the transfer moment
// - counter readable anytime and can delay transfers to a count
// - each transfer captures the counter as a readable timestamp
// - an enabled link takes its pins away from all ports
// - narrower enabled port wins shared pins; other pins stay wider
// - a port always transfers at its full width
// - six clock blocks; block zero runs at the reference rate
// - clock block may use the 1-bit port pin, optionally divided
// - ports accept incoming strobes and produce outgoing strobes
// - after reset all ports use clock block zero
// - pin events reach the core as interrupt through sticky status and a mask
module tio_port_unit
   import tio_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [5:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   output      logic [31:0]      avs_readdata,
   output      logic             avs_waitrequest,
   input  wire logic [NPIN-1:0]  pin_in,
   output      logic [NPIN-1:0]  pin_out,
   output      logic [NPIN-1:0]  pin_oe,
   input  wire logic [NPORT-1:0] strobe_from_source,
   output      logic [NPORT-1:0] strobe_to_sink,
   output      logic             link_enable,
   output      logic             irq
);
   // ***********************************************
   // state
   // ***********************************************
   logic [CTRL_W-1:0] ctrl      [NPORT];
   logic [NPIN-1:0]   xfer      [NPORT];
   logic [NPIN-1:0]   shift     [NPORT];
   logic [NPIN-1:0]   cond_val  [NPORT];
   logic [CNT_W-1:0]  time_val  [NPORT];
   logic [CNT_W-1:0]  count     [NPORT];
   logic [CNT_W-1:0]  stamp     [NPORT];
   logic [NPORT-1:0]  xfer_full;
   logic [15:0]       cb_cfg    [NCB];
   logic [7:0]        cb_cnt    [NCB];
   logic              pin0_last;
   logic [NPORT-1:0]  istat;
   logic [NPORT-1:0]  imask;
   logic              link_en;
   bus_t              bus_state;
   logic [NPIN-1:0]   oc_pins;

   logic [CTRL_W-1:0] next_ctrl     [NPORT];
   logic [NPIN-1:0]   next_xfer     [NPORT];
   logic [NPIN-1:0]   next_shift    [NPORT];
   logic [NPIN-1:0]   next_cond_val [NPORT];
   logic [CNT_W-1:0]  next_time_val [NPORT];
   logic [CNT_W-1:0]  next_count    [NPORT];
   logic [CNT_W-1:0]  next_stamp    [NPORT];
   logic [NPORT-1:0]  next_xfer_full;
   logic [NPORT-1:0]  next_strobe;
   logic [15:0]       next_cb_cfg   [NCB];
   logic [7:0]        next_cb_cnt   [NCB];
   logic [NPORT-1:0]  next_istat;
   logic [NPORT-1:0]  next_imask;
   logic              next_link_en;
   bus_t              next_bus_state;
   logic [31:0]       next_readdata;
   logic [NPIN-1:0]   next_pin_out;
   logic [NPIN-1:0]   next_pin_oe;
   logic [NPIN-1:0]   next_oc_pins;

   logic [NCB-1:0]    cb_tick;
   logic [NPORT-1:0]  fire;
   logic [NPORT-1:0]  tick;
   logic [NPORT-1:0]  time_ok;
   logic              wr;
   logic              rd_acc;
   logic [2:0]        pidx;
   logic [2:0]        fld;
   logic              port_hit;
   logic [2:0]        cbidx;

   assign pidx     = avs_address[5:3];
   assign fld      = avs_address[2:0];
   assign port_hit = (pidx < 3'(NPORT));
   assign cbidx    = 3'(avs_address - A_CB0);
   assign wr       = avs_write;
   assign avs_waitrequest = avs_read && (bus_state == BUS_IDLE);
   assign rd_acc   = avs_read && (bus_state == BUS_DONE);
   assign link_enable = link_en;
   assign irq = |(istat & imask);

   // ***********************************************
   // clock blocks
   // ***********************************************
   always_comb begin
      logic src_evt;
      src_evt = 1'b0;
      // block zero ticks every reference cycle
      cb_tick[0]     = 1'b1;
      next_cb_cnt[0] = 8'h00;
      next_cb_cfg[0] = CB_RST;
      for (int b = 1; b < NCB; b++) begin
         src_evt = cb_cfg[b][CB_SRC] ? (pin_in[0] && !pin0_last) : 1'b1;
         cb_tick[b]     = src_evt && (cb_cnt[b] == cb_cfg[b][CB_DIV +: 8]);
         next_cb_cnt[b] = cb_cnt[b];
         if (cb_tick[b]) begin
            next_cb_cnt[b] = 8'h00;
         end else if (src_evt) begin
            next_cb_cnt[b] = cb_cnt[b] + 8'h01;
         end
         next_cb_cfg[b] = cb_cfg[b];
         if (wr && avs_address >= A_CB0 + 6'h01
             && avs_address < A_CB0 + 6'(NCB) && cbidx == 3'(b)) begin
            next_cb_cfg[b] = avs_writedata[15:0];
         end
      end
   end

   // ***********************************************
   // ports
   // ***********************************************
   always_comb begin
      logic cond_ok;
      logic [NPIN-1:0] msk;
      cond_ok = 1'b0;
      msk = '0;
      next_istat   = istat;
      next_imask   = imask;
      next_link_en = link_en;
      if (wr && avs_address == A_IMASK) begin
         next_imask = avs_writedata[NPORT-1:0];
      end
      if (wr && avs_address == A_LINK) begin
         next_link_en = avs_writedata[0];
      end
      // set wins over the write-one clear
      if (wr && avs_address == A_ISTAT) begin
         next_istat = istat & ~avs_writedata[NPORT-1:0];
      end
      for (int k = 0; k < NPORT; k++) begin
         msk = port_mask(k);
         next_ctrl[k]     = ctrl[k];
         next_xfer[k]     = xfer[k];
         next_shift[k]    = shift[k];
         next_cond_val[k] = cond_val[k];
         next_time_val[k] = time_val[k];
         next_stamp[k]    = stamp[k];
         next_xfer_full[k] = xfer_full[k];
         next_strobe[k]   = 1'b0;
         // unused block codes give no tick rather than an unknown
         tick[k] = (ctrl[k][C_CB +: 3] < 3'(NCB))
            && cb_tick[ctrl[k][C_CB +: 3]];
         next_count[k] = tick[k] ? count[k] + 16'h0001 : count[k];
         time_ok[k] = !ctrl[k][C_TIMED] || (count[k] == time_val[k]);
         case (cond_t'(ctrl[k][C_CM +: 2]))
            COND_EQ: cond_ok = ((pin_in & msk) == cond_val[k]);
            COND_NE: cond_ok = ((pin_in & msk) != cond_val[k]);
            default: cond_ok = 1'b1;
         endcase
         fire[k] = 1'b0;
         if (ctrl[k][C_EN] && tick[k] && time_ok[k]) begin
            if (ctrl[k][C_OUT]) begin
               fire[k] = xfer_full[k];
            end else begin
               fire[k] = !xfer_full[k] && cond_ok
                  && (!ctrl[k][C_STRB] || strobe_from_source[k]);
            end
         end
         if (wr && port_hit && pidx == 3'(k)) begin
            if (fld == F_CTRL) begin
               next_ctrl[k] = avs_writedata[CTRL_W-1:0];
            end else if (fld == F_DATA) begin
               next_xfer[k]      = avs_writedata & msk;
               next_xfer_full[k] = 1'b1;
            end else if (fld == F_COND) begin
               next_cond_val[k] = avs_writedata & msk;
            end else if (fld == F_TIME) begin
               next_time_val[k] = avs_writedata[CNT_W-1:0];
            end
         end
         if (rd_acc && port_hit && pidx == 3'(k) && fld == F_DATA
             && !ctrl[k][C_OUT]) begin
            next_xfer_full[k] = 1'b0;
         end
         if (fire[k]) begin
            next_stamp[k] = count[k];
            next_istat[k] = 1'b1;
            if (ctrl[k][C_OUT]) begin
               // full-width move to the pin register
               next_shift[k]     = xfer[k];
               next_xfer_full[k] = 1'b0;
               next_strobe[k]    = ctrl[k][C_STRB];
            end else begin
               next_shift[k]     = pin_in & msk;
               next_xfer[k]      = pin_in & msk;
               next_xfer_full[k] = 1'b1;
            end
         end
      end
   end

   // ***********************************************
   // pin ownership
   // ***********************************************
   always_comb begin
      logic [2:0]      own;
      logic            has;
      logic [NPIN-1:0] pm;
      own = 3'h0;
      has = 1'b0;
      pm  = '0;
      for (int i = 0; i < NPIN; i++) begin
         own = 3'h0;
         has = 1'b0;
         for (int k = NPORT - 1; k >= 0; k--) begin
            pm = port_mask(k);
            if (ctrl[k][C_EN] && pm[i]) begin
               own = 3'(k);
               has = 1'b1;
            end
         end
         if (link_en && LINK_PINS[i]) begin
            has = 1'b0;
         end
         next_pin_out[i] = 1'b0;
         next_pin_oe[i]  = 1'b0;
         next_oc_pins[i] = 1'b0;
         if (has && ctrl[own][C_OUT]) begin
            if (ctrl[own][C_OC]) begin
               next_oc_pins[i] = 1'b1;
               next_pin_oe[i]  = !shift[own][i];
            end else begin
               next_pin_out[i] = shift[own][i];
               next_pin_oe[i]  = 1'b1;
            end
         end
      end
   end

   // ***********************************************
   // bus read
   // ***********************************************
   always_comb begin
      next_bus_state = bus_state;
      next_readdata  = avs_readdata;
      case (bus_state)
         BUS_IDLE: begin
            if (avs_read) begin
               next_bus_state = BUS_DONE;
               next_readdata  = 32'h0000_0000;
               if (port_hit) begin
                  if (fld == F_CTRL) begin
                     next_readdata = 32'(ctrl[pidx]);
                  end else if (fld == F_DATA) begin
                     next_readdata = xfer[pidx];
                  end else if (fld == F_COND) begin
                     next_readdata = cond_val[pidx];
                  end else if (fld == F_TIME) begin
                     next_readdata = 32'(time_val[pidx]);
                  end else if (fld == F_COUNT) begin
                     next_readdata = 32'(count[pidx]);
                  end else if (fld == F_STAMP) begin
                     next_readdata = 32'(stamp[pidx]);
                  end
               end else if (avs_address == A_LINK) begin
                  next_readdata = 32'(link_en);
               end else if (avs_address == A_ISTAT) begin
                  next_readdata = 32'(istat);
               end else if (avs_address == A_IMASK) begin
                  next_readdata = 32'(imask);
               end else if (avs_address >= A_CB0
                            && avs_address < A_CB0 + 6'(NCB)) begin
                  next_readdata = 32'(cb_cfg[cbidx]);
               end
            end
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int k = 0; k < NPORT; k++) begin
            ctrl[k]     <= CTRL_RST;
            xfer[k]     <= '0;
            shift[k]    <= '0;
            cond_val[k] <= '0;
            time_val[k] <= '0;
            count[k]    <= '0;
            stamp[k]    <= '0;
         end
         for (int b = 0; b < NCB; b++) begin
            cb_cfg[b] <= CB_RST;
            cb_cnt[b] <= 8'h00;
         end
         xfer_full      <= '0;
         strobe_to_sink <= '0;
         pin0_last      <= 1'b0;
         istat          <= '0;
         imask          <= '0;
         link_en        <= 1'b0;
         bus_state      <= BUS_IDLE;
         avs_readdata   <= 32'h0000_0000;
         pin_out        <= '0;
         pin_oe         <= '0;
         oc_pins        <= '0;
      end else begin
         for (int k = 0; k < NPORT; k++) begin
            ctrl[k]     <= next_ctrl[k];
            xfer[k]     <= next_xfer[k];
            shift[k]    <= next_shift[k];
            cond_val[k] <= next_cond_val[k];
            time_val[k] <= next_time_val[k];
            count[k]    <= next_count[k];
            stamp[k]    <= next_stamp[k];
         end
         for (int b = 0; b < NCB; b++) begin
            cb_cfg[b] <= next_cb_cfg[b];
            cb_cnt[b] <= next_cb_cnt[b];
         end
         xfer_full      <= next_xfer_full;
         strobe_to_sink <= next_strobe;
         pin0_last      <= pin_in[0];
         istat          <= next_istat;
         imask          <= next_imask;
         link_en        <= next_link_en;
         bus_state      <= next_bus_state;
         avs_readdata   <= next_readdata;
         pin_out        <= next_pin_out;
         pin_oe         <= next_pin_oe;
         oc_pins        <= next_oc_pins;
      end
   end

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb_main @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_read_wait;
      avs_read && avs_waitrequest;
   endsequence
   sequence s_read_done;
      avs_read && !avs_waitrequest;
   endsequence

   property p_read_one;
      s_read_wait ##1 avs_read |-> s_read_done;
   endproperty
   a_read_one: assert property (p_read_one)
      else $error("read not answered after one wait");

   property p_count_step;
      // sampled reset: the release edge itself gives no step yet
      !reset && ctrl[0][C_CB +: 3] == 3'h0
         |=> count[0] == $past(count[0]) + 16'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter on block zero did not step");

   property p_stamp;
      fire[1] |=> stamp[1] == $past(count[1]);
   endproperty
   a_stamp: assert property (p_stamp)
      else $error("timestamp not captured on transfer");

   property p_timed;
      ctrl[0][C_EN] && ctrl[0][C_OUT] && ctrl[0][C_TIMED] && xfer_full[0]
         && count[0] != time_val[0] |=> xfer_full[0];
   endproperty
   a_timed: assert property (p_timed)
      else $error("timed word left before its count");

   property p_link;
      link_en ##1 link_en |-> (pin_oe & LINK_PINS) == '0;
   endproperty
   a_link: assert property (p_link)
      else $error("port drives a link pin");

   property p_oc;
      (pin_out & oc_pins) == '0;
   endproperty
   a_oc: assert property (p_oc)
      else $error("open collector pin drives high");

   property p_in_quiet;
      ctrl[2][C_EN] && !ctrl[2][C_OUT] && !ctrl[1][C_EN] && !ctrl[0][C_EN]
         |=> pin_oe[7:0] == 8'h00;
   endproperty
   a_in_quiet: assert property (p_in_quiet)
      else $error("input port pin is driven");

   property p_sticky;
      istat[0] && !(wr && avs_address == A_ISTAT) |=> istat[0];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("event flag lost");

   property p_rx_hold;
      xfer_full[2] && !ctrl[2][C_OUT] && !rd_acc |=> xfer_full[2];
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("unread input word dropped");
endmodule // tio_port_unit

// ===== tb/pin_side_model.sv
/*
 * board-side model of what hangs on the unit's pins and strobes.
 * assumes one clock; a board pull-up on every pin, so a released
 * open-collector line reads high; bench sets drive_en/drive_val.
 */
module pin_side_model
   import tio_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [NPIN-1:0]  pin_out,
   input  wire logic [NPIN-1:0]  pin_oe,
   input  wire logic [NPORT-1:0] strobe_to_sink,
   input  wire logic [NPIN-1:0]  drive_val,
   input  wire logic             drive_en,
   input  wire logic             strobe_level,
   output      logic [NPIN-1:0]  pin_in,
   output      logic [NPIN-1:0]  pin_level,
   output      logic [NPORT-1:0] strobe_from_source,
   output      logic [7:0]       strobe_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************
   // wire resolution
   // ***********************************************
   // released line floats up
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (pin_oe[i]) begin
            pin_level[i] = pin_out[i];
         end else if (drive_en) begin
            pin_level[i] = drive_val[i];
         end else begin
            pin_level[i] = 1'b1;
         end
      end
   end
   assign pin_in = pin_level;
   // ***********************************************
   // strobes
   // ***********************************************
   // source strobe and sink count
   assign strobe_from_source = {NPORT{strobe_level}};
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         strobe_count <= 8'h00;
      end else if (|strobe_to_sink) begin
         strobe_count <= strobe_count + 8'h01;
      end
   end
endmodule // pin_side_model

// ===== tb/timed_io_port_with_clock_blocks_tb.sv
/*
 * self-checking bench for the timed pin port unit.
 * assumes pin_side_model on the pins and Avalon-MM master tasks here.
 */
module timed_io_port_with_clock_blocks_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tio_pkg::*;
   typedef struct {
      logic        wr;
      logic [5:0]  addr;
      logic [31:0] wd;
      logic [31:0] exp;
   } row_t;
   logic             ref_clk, reset, avs_read, avs_write, link_enable, irq;
   logic [5:0]       avs_address;
   logic [31:0]      avs_writedata, avs_readdata, rd, c0;
   logic             avs_waitrequest, drive_en, strobe_level;
   logic [NPIN-1:0]  pin_in, pin_out, pin_oe, drive_val, pin_level;
   logic [NPORT-1:0] strobe_from_source, strobe_to_sink;
   logic [7:0]       strobe_count;
   logic [15:0]      dc;
   int               n_mismatch = 0;
   int               comparisons = 0;
   // cb0 is fixed, unmapped place reads zero
   row_t rows[8] = '{
      '{1'b0, 6'h00, 32'h0, 32'h0}, '{1'b0, 6'h20, 32'h0, 32'h0},
      '{1'b0, 6'h30, 32'h0, 32'h0}, '{1'b1, 6'h30, 32'hffff, 32'h0},
      '{1'b1, 6'h31, 32'h0301, 32'h0301}, '{1'b1, 6'h3f, 32'h1234, 32'h0},
      '{1'b1, 6'h02, 32'h1, 32'h1}, '{1'b0, 6'h29, 32'h0, 32'h0}};

   tio_port_unit i_dut (.ref_clk(ref_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .strobe_from_source(strobe_from_source),
      .strobe_to_sink(strobe_to_sink), .link_enable(link_enable),
      .irq(irq));
   pin_side_model i_pins (.ref_clk(ref_clk), .reset(reset),
      .pin_out(pin_out), .pin_oe(pin_oe), .strobe_to_sink(strobe_to_sink),
      .drive_val(drive_val), .drive_en(drive_en),
      .strobe_level(strobe_level), .pin_in(pin_in), .pin_level(pin_level),
      .strobe_from_source(strobe_from_source),
      .strobe_count(strobe_count));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ***********************************************
   // helpers
   // ***********************************************
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus_access(input logic wr, input logic [5:0] a,
                             input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_address   <= a;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      check("bus cycles", 32'(n), wr ? 32'h1 : 32'h2);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_access(1'b1, a, d, q);
   endtask
   task automatic bus_read(input logic [5:0] a, output logic [31:0] q);
      bus_access(1'b0, a, 32'h0, q);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      check("event raised", 32'(irq), 32'h1);
   endtask
   // ***********************************************
   // watchdog: whole run is well under 2000 cycles
   // ***********************************************
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      stop_test();
   end
   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      reset = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      drive_en = 1'b0;
      drive_val = 32'h0;
      strobe_level = 1'b0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            bus_write(rows[i].addr, rows[i].wd);
         end
         bus_read(rows[i].addr, rd);
         check("table read", rd, rows[i].exp);
      end
      $display("test table done");
      // back-to-back reads load three cycles apart
      bus_read(6'(F_COUNT), c0);
      bus_read(6'(F_COUNT), rd);
      dc = rd[15:0] - c0[15:0];
      check("count step", {16'h0, dc}, 32'h3);
      $display("test counter done");
      bus_write(A_IMASK, 32'h1);
      bus_write(6'h00, 32'h13);
      bus_write(6'h01, 32'h1);
      wait_irq();
      repeat (2) @(posedge ref_clk);
      check("strobe pulses", 32'(strobe_count), 32'h1);
      check("pin0 driven", 32'({pin_oe[0], pin_level[0]}), 32'h3);
      bus_write(A_IMASK, 32'h0);
      @(posedge ref_clk);
      check("irq masked", 32'(irq), 32'h0);
      bus_read(A_ISTAT, rd);
      check("status sticky", rd, 32'h1);
      bus_write(A_ISTAT, 32'h1);
      bus_read(A_ISTAT, rd);
      check("status cleared", rd, 32'h0);
      $display("test output done");
      bus_write(A_IMASK, 32'h1);
      bus_read(6'h04, c0);
      bus_write(6'h03, 32'(c0[15:0] + 16'h0028));
      bus_write(6'h00, 32'h0b);
      bus_write(6'h01, 32'h1);
      repeat (20) @(posedge ref_clk);
      check("timed holds", 32'(irq), 32'h0);
      wait_irq();
      bus_read(6'h05, rd);
      check("stamp at time", rd, 32'(c0[15:0] + 16'h0028));
      $display("test timed done");
      bus_write(A_IMASK, 32'h2);
      bus_write(6'h08, 32'h7);
      bus_write(6'h09, 32'ha);
      wait_irq();
      repeat (2) @(posedge ref_clk);
      check("oc enables", 32'(pin_oe[3:0]), 32'h5);
      check("oc levels", 32'(pin_level[3:0]), 32'hb);
      $display("test open collector done");
      bus_write(A_LINK, 32'h1);
      bus_write(A_IMASK, 32'h10);
      bus_write(6'h20, 32'h3);
      bus_write(6'h21, 32'hffff_ffff);
      wait_irq();
      repeat (2) @(posedge ref_clk);
      check("link flag", 32'(link_enable), 32'h1);
      check("link pins", 32'(pin_oe[31:30]), 32'h0);
      check("wide pins", 32'(pin_oe[29:4]), 32'h3ff_ffff);
      bus_write(A_LINK, 32'h0);
      repeat (3) @(posedge ref_clk);
      check("pins back", 32'(pin_out[31:30] & pin_oe[31:30]), 32'h3);
      $display("test link done");
      for (int k = 0; k < NPORT; k++) begin
         bus_write(6'(k * 8), 32'h0);
      end
      drive_en <= 1'b1;
      drive_val <= 32'hffff_ff33;
      strobe_level <= 1'b1;
      bus_write(A_IMASK, 32'h4);
      bus_write(6'h12, 32'h5a);
      bus_write(6'h10, 32'h31);
      repeat (20) @(posedge ref_clk);
      check("cond blocks", 32'(irq), 32'h0);
      drive_val <= 32'hffff_ff5a;
      strobe_level <= 1'b0;
      repeat (20) @(posedge ref_clk);
      check("strobe blocks", 32'(irq), 32'h0);
      strobe_level <= 1'b1;
      wait_irq();
      bus_read(6'h11, rd);
      check("captured word", rd, 32'h5a);
      $display("test input done");
      bus_write(6'h18, 32'h101);
      bus_read(6'h1c, c0);
      // eight rising pin edges through a divide-by-four block
      repeat (8) begin
         drive_val[0] <= 1'b0;
         @(posedge ref_clk);
         drive_val[0] <= 1'b1;
         @(posedge ref_clk);
      end
      bus_read(6'h1c, rd);
      dc = rd[15:0] - c0[15:0];
      check("pin clock ticks", {16'h0, dc}, 32'h2);
      $display("test clock block done");
      reset <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check("reset oe", pin_oe, 32'h0);
      check("reset irq", 32'(irq | link_enable), 32'h0);
      reset <= 1'b0;
      bus_read(6'h10, rd);
      check("ctrl after reset", rd, 32'h0);
      $display("test reset done");
      stop_test();
   end
endmodule // timed_io_port_with_clock_blocks_tb
